// File: anmr_pkg.sv
`default_nettype none

package anmr_pkg;

    // Register addresses on the management register port
    localparam logic [4:0] ADDR_AN_EXP = 5'h06;
    localparam logic [4:0] ADDR_LOC_NP = 5'h07;
    localparam logic [4:0] ADDR_LP_NP = 5'h08;
    localparam logic [4:0] ADDR_PRE_CTL = 5'h14;
    localparam logic [4:0] ADDR_SYM_CNT = 5'h15;

    // Expansion flag bit positions
    localparam int EXP_PD_FAULT = 4;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN_ABLE = 0;

    // Next-page word bit positions
    localparam int NP_MORE = 15;
    localparam int NP_ACK = 14;
    localparam int NP_MSG_PAGE = 13;
    localparam int NP_COMPLY = 12;
    localparam int NP_TOGGLE = 11;
    localparam int NP_CODE_MSB = 10;

    // Writable bits of the local next-page word
    localparam logic [15:0] LOC_NP_WR_MASK = 16'hB7FF;
    localparam logic [15:0] LOC_NP_RESET = 16'h2001;
    localparam logic [15:0] LP_NP_RESET = 16'h0000;

    // Preamble control bit positions and fixed read-back
    localparam int PRE_RESTORE_100 = 7;
    localparam int PRE_RESTORE_10 = 6;
    localparam logic [5:0] PRE_LOW_READBACK = 6'h01;
    localparam logic [2:0] STRAP_RESTORE_100 = 3'h4;
    localparam logic PRE_RESTORE_10_RESET = 1'b0;

    // Local next-page ability read-back and counter reset
    localparam logic NP_ABLE_RESET = 1'b1;
    localparam logic [15:0] SYM_CNT_RESET = 16'h0000;

    // Nibbles removed from the head of a received frame
    localparam logic [4:0] STRIP_NIB_100 = 5'h02;
    localparam logic [4:0] STRIP_NIB_10 = 5'h0E;

endpackage

`default_nettype wire

// File: anmr_latch_flag.sv
`timescale 1ns/1ns
`default_nettype none

module anmr_latch_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic cond,
    input wire logic rd_clr,
    output logic flag_r
);

    // A condition seen in the clearing cycle keeps the flag set
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (cond) begin
            flag_r <= 1'b1;
        end else if (rd_clr) begin
            flag_r <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: anmr_sat_counter.sv
`timescale 1ns/1ns
`default_nettype none

module anmr_sat_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inc,
    input wire logic rd_clr,
    output logic [W-1:0] cnt_r
);

    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = rd_clr ? '0 : cnt_r;
        // Saturate rather than wrap; an increment during the clearing read counts
        if (inc && (cnt_nxt != {W{1'b1}})) begin
            cnt_nxt = cnt_nxt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

`default_nettype wire

// File: anmr_regs.sv
// Overview of operation
// - Parallel detect fault latches until read
// - Partner next-page ability shown, resets zero
// - Local next-page ability reads one
// - Page received flag latches, resets zero
// - Partner auto-negotiation ability shown, resets zero
// - Writable more-pages bit, resets zero
// - Writable message page select, resets one
// - Writable comply bit, resets zero
// - Toggle bit tracks transmitted word toggle
// - Writable eleven-bit message code, resets 001
// - Capture partner more-pages indication
// - Capture partner acknowledge bit
// - Capture partner comply indication
// - Capture partner toggle bit as received
// - Fast mode drops one preamble byte unless restored
// - Fast restore resets from strap value 100
// - Slow mode strips seven preamble bytes unless restored
// - Sixteen-bit symbol error frame counter, read clears
`timescale 1ns/1ns
`default_nettype none

module anmr_regs #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] strap_config,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_r,
    input wire logic pd_fault,
    input wire logic lp_np_able,
    input wire logic lp_an_able,
    input wire logic page_rx,
    input wire logic np_sent,
    input wire logic lp_np_valid,
    input wire logic [15:0] lp_np_word,
    input wire logic speed_100,
    input wire logic rx_dv_in,
    input wire logic [3:0] rx_nib_in,
    input wire logic rx_symbol_error,
    output logic [15:0] np_tx_word_r,
    output logic rx_dv_r,
    output logic [3:0] rx_nib_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Access decode

    logic rd_exp;
    logic rd_cnt;
    logic wr_loc;
    logic wr_pre;

    // Other addresses decode to nothing, so stray writes change no state
    assign rd_exp = reg_rd && (reg_addr == anmr_pkg::ADDR_AN_EXP);
    assign rd_cnt = reg_rd && (reg_addr == anmr_pkg::ADDR_SYM_CNT);
    assign wr_loc = reg_wr && (reg_addr == anmr_pkg::ADDR_LOC_NP);
    assign wr_pre = reg_wr && (reg_addr == anmr_pkg::ADDR_PRE_CTL);

    ////////////////////////////////////////////////////////////////////////////
    // Expansion flags

    logic pd_fault_r;
    logic page_rx_r;
    logic lp_np_able_r;
    logic lp_an_able_r;

    // One read of the flag register clears both latched flags
    anmr_latch_flag u_pd_fault (
        .clk(clk),
        .rst(rst),
        .cond(pd_fault),
        .rd_clr(rd_exp),
        .flag_r(pd_fault_r)
    );

    anmr_latch_flag u_page_rx (
        .clk(clk),
        .rst(rst),
        .cond(page_rx),
        .rd_clr(rd_exp),
        .flag_r(page_rx_r)
    );

    // Partner abilities are plain status, registered to keep reads glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            lp_np_able_r <= 1'b0;
        end else begin
            lp_np_able_r <= lp_np_able;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lp_an_able_r <= 1'b0;
        end else begin
            lp_an_able_r <= lp_an_able;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Local next-page word

    // A write and a page send in one cycle both take effect
    always_ff @(posedge clk) begin
        if (rst) begin
            np_tx_word_r <= anmr_pkg::LOC_NP_RESET;
        end else begin
            if (wr_loc) begin
                np_tx_word_r <= (reg_wdata & anmr_pkg::LOC_NP_WR_MASK)
                    | (np_tx_word_r & ~anmr_pkg::LOC_NP_WR_MASK);
            end
            // Toggle follows each transmitted page; software cannot write it
            if (np_sent) begin
                np_tx_word_r[anmr_pkg::NP_TOGGLE] <= ~np_tx_word_r[anmr_pkg::NP_TOGGLE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Partner next-page word

    logic [15:0] lp_np_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            lp_np_r <= anmr_pkg::LP_NP_RESET;
        end else if (lp_np_valid) begin
            // Whole word taken at once so the fields always belong together
            lp_np_r <= lp_np_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Preamble control

    logic pre_restore_100_r;
    logic pre_restore_10_r;

    // Strap is taken on every reset edge, so it must stay steady while rst is high
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_restore_100_r <= (strap_config == anmr_pkg::STRAP_RESTORE_100);
        end else if (wr_pre) begin
            pre_restore_100_r <= reg_wdata[anmr_pkg::PRE_RESTORE_100];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_restore_10_r <= anmr_pkg::PRE_RESTORE_10_RESET;
        end else if (wr_pre) begin
            pre_restore_10_r <= reg_wdata[anmr_pkg::PRE_RESTORE_10];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path preamble handling

    typedef enum logic [1:0] {
        ANMR_IDLE,
        ANMR_STRIP,
        ANMR_PASS
    } anmr_rx_e;

    anmr_rx_e rx_state_r;
    logic [4:0] strip_left_r;
    logic [4:0] strip_need;
    logic restore;

    assign restore = speed_100 ? pre_restore_100_r : pre_restore_10_r;
    assign strip_need = speed_100 ? anmr_pkg::STRIP_NIB_100 : anmr_pkg::STRIP_NIB_10;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state_r <= ANMR_IDLE;
        end else begin
            unique case (rx_state_r)
                ANMR_IDLE: begin
                    // Mode is sampled at frame start so a frame is never cut mid-way
                    if (rx_dv_in) begin
                        if (restore) begin
                            rx_state_r <= ANMR_PASS;
                        end else begin
                            rx_state_r <= ANMR_STRIP;
                        end
                    end
                end
                ANMR_STRIP: begin
                    // A frame that ends while stripping forwards nothing
                    if (!rx_dv_in) begin
                        rx_state_r <= ANMR_IDLE;
                    end else if (strip_left_r == 5'h01) begin
                        rx_state_r <= ANMR_PASS;
                    end
                end
                ANMR_PASS: begin
                    if (!rx_dv_in) begin
                        rx_state_r <= ANMR_IDLE;
                    end
                end
            endcase
        end
    end

    // The first nibble is dropped in idle, so the count starts one short
    always_ff @(posedge clk) begin
        if (rst) begin
            strip_left_r <= 5'h00;
        end else if ((rx_state_r == ANMR_IDLE) && rx_dv_in) begin
            strip_left_r <= strip_need - 5'h01;
        end else if ((rx_state_r == ANMR_STRIP) && (strip_left_r != 5'h00)) begin
            strip_left_r <= strip_left_r - 5'h01;
        end
    end

    logic fwd;

    // Dropped nibbles never reach the output; valid stays low across them
    assign fwd = rx_dv_in && ((rx_state_r == ANMR_PASS)
        || ((rx_state_r == ANMR_IDLE) && restore));

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_dv_r <= 1'b0;
            rx_nib_r <= 4'h0;
        end else begin
            rx_dv_r <= fwd;
            rx_nib_r <= fwd ? rx_nib_in : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Symbol error frame counter

    logic err_seen_r;
    logic dv_d_r;
    logic frame_err_end;
    logic [CNT_W-1:0] sym_cnt_r;

    // A frame counts once however many error symbols it held
    always_ff @(posedge clk) begin
        if (rst) begin
            err_seen_r <= 1'b0;
        end else if (!rx_dv_in) begin
            err_seen_r <= 1'b0;
        end else if (rx_symbol_error) begin
            err_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dv_d_r <= 1'b0;
        end else begin
            dv_d_r <= rx_dv_in;
        end
    end

    // Counting at frame end needs one clock with valid low
    assign frame_err_end = dv_d_r && !rx_dv_in && err_seen_r;

    anmr_sat_counter #(
        .W(CNT_W)
    ) u_sym_cnt (
        .clk(clk),
        .rst(rst),
        .inc(frame_err_end),
        .rd_clr(rd_cnt),
        .cnt_r(sym_cnt_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [15:0] exp_word;
    logic [15:0] pre_word;
    logic [15:0] cnt_word;
    logic [15:0] rdata_nxt;

    // Reserved bits are built as zero here so the read select stays a plain mux
    always_comb begin
        exp_word = 16'h0000;
        exp_word[anmr_pkg::EXP_PD_FAULT] = pd_fault_r;
        exp_word[anmr_pkg::EXP_LP_NP_ABLE] = lp_np_able_r;
        exp_word[anmr_pkg::EXP_NP_ABLE] = anmr_pkg::NP_ABLE_RESET;
        exp_word[anmr_pkg::EXP_PAGE_RX] = page_rx_r;
        exp_word[anmr_pkg::EXP_LP_AN_ABLE] = lp_an_able_r;
    end

    always_comb begin
        pre_word = 16'h0000;
        pre_word[anmr_pkg::PRE_RESTORE_100] = pre_restore_100_r;
        pre_word[anmr_pkg::PRE_RESTORE_10] = pre_restore_10_r;
        pre_word[5:0] = anmr_pkg::PRE_LOW_READBACK;
    end

    // A build with a narrower counter reads back zero-extended
    always_comb begin
        cnt_word = 16'h0000;
        cnt_word[CNT_W-1:0] = sym_cnt_r;
    end

    always_comb begin
        unique case (reg_addr)
            anmr_pkg::ADDR_AN_EXP: begin
                rdata_nxt = exp_word;
            end
            anmr_pkg::ADDR_LOC_NP: begin
                rdata_nxt = np_tx_word_r;
            end
            anmr_pkg::ADDR_LP_NP: begin
                rdata_nxt = lp_np_r;
            end
            anmr_pkg::ADDR_PRE_CTL: begin
                rdata_nxt = pre_word;
            end
            anmr_pkg::ADDR_SYM_CNT: begin
                rdata_nxt = cnt_word;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    // Data shows the value before any clear that the same read causes
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

endmodule

`default_nettype wire

// File: anmr_regs_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module anmr_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_r,
    input wire logic pd_fault,
    input wire logic lp_np_able,
    input wire logic lp_an_able,
    input wire logic np_sent,
    input wire logic lp_np_valid,
    input wire logic [15:0] lp_np_word,
    input wire logic rx_dv_in,
    input wire logic [3:0] rx_nib_in,
    input wire logic [15:0] np_tx_word_r,
    input wire logic rx_dv_r,
    input wire logic [3:0] rx_nib_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_pd_latch: assert property (pd_fault ##1 !reg_rd ##1 (reg_rd && reg_addr == 5'h06)
        |=> reg_rdata_r[4]) else $error("fault flag lost before read");
    a_exp_const: assert property (reg_rd && reg_addr == 5'h06
        |=> reg_rdata_r[15:5] == 11'h000 && reg_rdata_r[2]) else $error("expansion constants wrong");
    a_lp_levels: assert property ((lp_an_able && lp_np_able) ##1 (reg_rd && reg_addr == 5'h06)
        |=> reg_rdata_r[0] && reg_rdata_r[3]) else $error("partner ability not shown");
    a_toggle_flip: assert property (np_sent |=> np_tx_word_r[11] != $past(np_tx_word_r[11]))
        else $error("toggle did not flip");
    a_wr_mask: assert property (reg_wr && reg_addr == 5'h07 && !np_sent
        |=> np_tx_word_r == (($past(reg_wdata) & 16'hB7FF) | ($past(np_tx_word_r) & 16'h4800)))
        else $error("next page write mask wrong");
    a_lp_capture: assert property (lp_np_valid ##2 (reg_rd && reg_addr == 5'h08)
        |=> reg_rdata_r == $past(lp_np_word, 3)) else $error("partner word not captured");
    a_fwd_nibble: assert property (rx_dv_r |-> $past(rx_dv_in) && rx_nib_r == $past(rx_nib_in))
        else $error("forwarded nibble mismatch");
    a_cnt_clear: assert property (!rx_dv_in ##1 (reg_rd && reg_addr == 5'h15 && !rx_dv_in)
        ##1 !rx_dv_in ##1 (reg_rd && reg_addr == 5'h15 && !rx_dv_in) |=> reg_rdata_r == 16'h0000)
        else $error("counter not cleared by read");
    cover property (pd_fault);
    cover property (lp_np_valid);
    cover property ($rose(rx_dv_r));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind anmr_regs anmr_regs_chk u_chk (.*);
`default_nettype wire

// File: anmr_mgmt_model.sv
`timescale 1ns/1ns
`default_nettype none
module anmr_mgmt_model (
    input wire logic clk,
    input wire logic [15:0] reg_rdata_r,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 16'h0000;
    end
    // Idle address and data are inverted so a decoder cannot lean on stale values
    task wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'h1;
        @(posedge clk);
        #1 reg_wr = 1'h0;
        reg_wdata = ~v;
        reg_addr = ~a;
    endtask
    task rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1'h1;
        @(posedge clk);
        #1 reg_rd = 1'h0;
        v = reg_rdata_r;
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// File: autoneg_page_and_mii_ctrl_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module autoneg_page_and_mii_ctrl_regs_tb;
    logic clk, rst, reg_wr, reg_rd, pd_fault, lp_np_able, lp_an_able, page_rx, np_sent;
    logic lp_np_valid, speed_100, rx_dv_in, rx_symbol_error, rx_dv_r;
    logic [2:0] strap_config;
    logic [4:0] reg_addr;
    logic [3:0] rx_nib_in, rx_nib_r;
    logic [15:0] reg_wdata, reg_rdata_r, lp_np_word, np_tx_word_r, d, w;
    logic [31:0] seed = 32'h1914EC26;
    int miscompares = 0, checked = 0, seen = 0;
    localparam int CW = 4;
    localparam logic [4:0] AD [6] = '{5'h06, 5'h07, 5'h08, 5'h14, 5'h15, 5'h1F};
    localparam logic [15:0] EV [6] = '{16'h0004, 16'h2001, 16'h0000, 16'h0081, 16'h0000, 16'h0000};

    anmr_regs #(.CNT_W(CW)) dut (.*);
    anmr_mgmt_model mgmt (.*);

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (rx_dv_r === 1'h1) seen++;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction
    function automatic int drop(input logic s100, input logic rest);
        if (rest) return 0;
        return s100 ? 2 : 14;
    endfunction
    function automatic logic [15:0] pre_exp(input logic [15:0] v);
        return {8'h00, v[7:6], 6'h01};
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick();
        @(posedge clk);
        #1;
    endtask
    task print_verdict();
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task frame(input int n, input logic err);
        seen = 0;
        for (int i = 0; i < n; i++) begin
            tick();
            w = rnd();
            rx_dv_in = 1'h1;
            rx_nib_in = w[3:0];
            rx_symbol_error = err && (i == n / 2);
        end
        tick();
        rx_dv_in = 1'h0;
        rx_symbol_error = 1'h0;
        rx_nib_in = ~rx_nib_in;
        repeat (3) tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
    initial begin
        rst = 1'h1;
        strap_config = 3'h4;
        speed_100 = 1'h1;
        rx_nib_in = 4'h0;
        lp_np_word = 16'h0000;
        {pd_fault, lp_np_able, lp_an_able, page_rx, np_sent, lp_np_valid, rx_dv_in} = 7'h00;
        rx_symbol_error = 1'h0;
        repeat (3) @(posedge clk);
        #1 rst = 1'h0;
        chk(np_tx_word_r, 16'h2001);
        // Second pass writes every read-only place first, which must change nothing
        for (int p = 0; p < 2; p++) foreach (AD[i]) begin
            if (p == 1 && i != 1 && i != 3) mgmt.wr(AD[i], rnd());
            mgmt.rd(AD[i], d);
            chk(d, EV[i]);
        end
        w = rnd();
        mgmt.wr(5'h07, w);
        chk(np_tx_word_r, w & 16'hB7FF);
        tick();
        np_sent = 1'h1;
        tick();
        np_sent = 1'h0;
        mgmt.rd(5'h07, d);
        chk(d, (w & 16'hB7FF) ^ 16'h0800);
        for (int m = 0; m < 4; m++) begin
            w = m[1] ? 16'h00C0 : rnd() & 16'hFF3F;
            mgmt.wr(5'h14, w);
            mgmt.rd(5'h14, d);
            chk(d, pre_exp(w));
            speed_100 = m[0];
            frame(20, 1'h1);
            chk(16'(seen), 16'(20 - drop(m[0], m[1])));
        end
        mgmt.rd(5'h15, d);
        chk(d, 16'h0004);
        mgmt.rd(5'h15, d);
        chk(d, 16'h0000);
        repeat (2 ** CW + 1) frame(3, 1'h1);
        mgmt.rd(5'h15, d);
        chk(d, 16'((2 ** CW) - 1));
        tick();
        pd_fault = 1'h1;
        page_rx = 1'h1;
        tick();
        pd_fault = 1'h0;
        page_rx = 1'h0;
        mgmt.rd(5'h06, d);
        chk(d, 16'h0016);
        mgmt.rd(5'h06, d);
        chk(d, 16'h0004);
        lp_np_able = 1'h1;
        lp_an_able = 1'h1;
        mgmt.rd(5'h06, d);
        chk(d, 16'h000D);
        w = rnd();
        lp_np_word = w;
        lp_np_valid = 1'h1;
        tick();
        lp_np_valid = 1'h0;
        lp_np_word = ~w;
        mgmt.rd(5'h08, d);
        chk(d, w);
        rst = 1'h1;
        strap_config = 3'h0;
        repeat (3) tick();
        rst = 1'h0;
        mgmt.rd(5'h14, d);
        chk(d, 16'h0001);
        print_verdict();
    end
endmodule
`default_nettype wire
